// ---- logic/psc_defines.svh ----
// register offsets, write masks, reset values and timing counts for the packet sequencer
//Contract
//R01 - data path bit: 0 continuous, 1 packet
//R02 - compat enable bit, resets low
//R03 - beacon mode needs enable and fixed format
//R04 - payload length eleven bits, low resets 0x40
//R05 - fixed uses length exactly, variable as rx max; code accepts any rx length when the length is zero
//R06 - compare address against own station address
//R07 - also accept all-stations address when configured
//R08 - send trigger: above limit or not empty
//R09 - level irq when count >= limit plus one
//R10 - writing go bit runs start transition from idle
//R11 - host starts only from sleep or standby
//R12 - halt bit forces idle, reads zero
//R13 - low-power state: standby or sleep by bit
//R14 - idle next select picks start destination
//R15 - after action rest in idle or low-power
//R16 - timer one moves low-power to send or receive
//R17 - frame done moves send to rest or receive
//R18 - length format: 0 fixed, 1 variable
//R19 - timer tick select: off, 64us, 4.1ms, 262ms
//R20 - marker length is field plus one, compat field; code fixes the field at 3: 4 bytes, 3 in compat
//R21 - reset to idle; go ignored unless resting chip
//R22 - unused bits read zero, ignore writes
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
`define PSC_OFF_OPT2      8'h31
`define PSC_OFF_LEN_LO    8'h32
`define PSC_OFF_OWN       8'h33
`define PSC_OFF_ALL       8'h34
`define PSC_OFF_QSETUP    8'h35
`define PSC_OFF_SEQ1      8'h36
`define PSC_OFF_AUX       8'h3a
`define PSC_OFF_STAT      8'h3b
`define PSC_RST_OPT2      8'h40
`define PSC_RST_LEN_LO    8'h40
`define PSC_RST_OWN       8'h00
`define PSC_RST_ALL       8'h00
`define PSC_RST_QSETUP    8'h0f
`define PSC_RST_SEQ1      8'h00
`define PSC_RST_AUX       8'h0b
`define PSC_MASK_OPT2     8'h7f
`define PSC_MASK_QSETUP   8'hbf
`define PSC_MASK_SEQ1     8'h3f
`define PSC_MASK_AUX      8'h1f
`define PSC_CLK_HZ        10000000
`define PSC_TICK1_NS      64000
`define PSC_TICK2_NS      4100000
`define PSC_TICK3_NS      262000000
`define PSC_TICK1_CYC     ((`PSC_TICK1_NS / 1000) * (`PSC_CLK_HZ / 1000000))
`define PSC_TICK2_CYC     ((`PSC_TICK2_NS / 1000) * (`PSC_CLK_HZ / 1000000))
`define PSC_TICK3_CYC     ((`PSC_TICK3_NS / 1000) * (`PSC_CLK_HZ / 1000000))
`endif

// ---- logic/psc_pkg.sv ----
// types of the packet sequencer block
package psc_pkg;
    typedef enum logic [2:0] {
        PSC_IDLE    = 3'b000,
        PSC_REST    = 3'b001,
        PSC_RECV    = 3'b010,
        PSC_SEND    = 3'b011,
        PSC_QWAIT   = 3'b100
    } psc_seq_t;
    typedef enum logic [1:0] {
        PSC_CHIP_STBY  = 2'b00,
        PSC_CHIP_SLEEP = 2'b01,
        PSC_CHIP_ACT   = 2'b10
    } psc_chip_t;
    typedef struct packed {
        logic [7:0] opt2;
        logic [7:0] len_lo;
        logic [7:0] own;
        logic [7:0] all;
        logic [7:0] qsetup;
        logic [7:0] seq1;
        logic [7:0] aux;
    } psc_regs_t;
    typedef struct packed {
        logic       ack;
        logic [7:0] dat;
    } psc_wbr_t;
    typedef struct packed {
        psc_regs_t  regs;
        psc_wbr_t   wb;
        psc_seq_t   seq;
        psc_chip_t  chip;
        logic [21:0] tick_cnt;
        logic        tick;
        logic [7:0]  coef_cnt;
        logic        timer1_irq;
        logic        level_irq;
        logic        send_go;
        logic        addr_ok;
        logic        len_ok;
    } psc_state_t;
endpackage : psc_pkg

// ---- logic/psc_top.sv ----
// packet handler configuration and top-level sequencer with wishbone registers
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "psc_defines.svh"
module psc_top
    import psc_pkg::*;
#(
    parameter int unsigned TICK1_CYC = `PSC_TICK1_CYC,
    parameter int unsigned TICK2_CYC = `PSC_TICK2_CYC,
    parameter int unsigned TICK3_CYC = `PSC_TICK3_CYC,
    parameter int unsigned FIFO_W    = 7
)(
    input  wire logic              CLK_IN,
    input  wire logic              RESET_IN,
    input  wire logic              WB_CYC_IN,
    input  wire logic              WB_STB_IN,
    input  wire logic              WB_WE_IN,
    input  wire logic [7:0]        WB_ADR_IN,
    input  wire logic [3:0]        WB_SEL_IN,
    input  wire logic [31:0]       WB_DAT_IN,
    output var  logic [31:0]       WB_DAT_OUT,
    output var  logic              WB_ACK_OUT,
    input  wire logic [FIFO_W-1:0] FIFO_COUNT_IN,
    input  wire logic              FRAME_DONE_IN,
    input  wire logic              RX_DONE_IN,
    input  wire logic [7:0]        RX_ADDR_IN,
    input  wire logic [10:0]       RX_LEN_IN,
    output var  logic [2:0]        SEQ_STATE_OUT,
    output var  logic [1:0]        CHIP_MODE_OUT,
    output var  logic              QUEUE_LEVEL_IRQ_OUT,
    output var  logic              SEND_START_OUT,
    output var  logic              ADDR_MATCH_OUT,
    output var  logic              LEN_OK_OUT,
    output var  logic [3:0]        MARKER_BYTES_OUT,
    output var  logic [10:0]       BODY_LENGTH_OUT,
    output var  logic              PACKET_MODE_OUT,
    output var  logic              COMPAT_OUT,
    output var  logic              BEACON_OUT,
    output var  logic              VARIABLE_LEN_OUT
);
    initial
    begin
        if (FIFO_W < 7 || TICK1_CYC < 1 || TICK2_CYC < 1 || TICK3_CYC < 1 || TICK3_CYC > 4194303)
            $error("psc_top: unsupported parameter values");
    end

    psc_state_t s_r;
    psc_state_t s_nxt;
    logic [FIFO_W-1:0] fc_a_r;
    logic [FIFO_W-1:0] fc_b_r;
    logic [2:0] ev_a_r;
    logic [2:0] ev_b_r;
    logic [7:0] ra_a_r;
    logic [7:0] ra_b_r;
    logic [10:0] rl_a_r;
    logic [10:0] rl_b_r;

    // pins from the modem side pass two flops; first stage feeds only the second
    always_ff @(posedge CLK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            fc_a_r <= '0;
            fc_b_r <= '0;
            ev_a_r <= 3'h0;
            ev_b_r <= 3'h0;
            ra_a_r <= 8'h00;
            ra_b_r <= 8'h00;
            rl_a_r <= 11'h000;
            rl_b_r <= 11'h000;
        end
        else
        begin
            fc_a_r <= FIFO_COUNT_IN;
            fc_b_r <= fc_a_r;
            ev_a_r <= {RX_DONE_IN, FRAME_DONE_IN, 1'b0};
            ev_b_r <= ev_a_r;
            ra_a_r <= RX_ADDR_IN;
            ra_b_r <= ra_a_r;
            rl_a_r <= RX_LEN_IN;
            rl_b_r <= rl_a_r;
        end
    end

    function automatic logic [7:0] wr_lane(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] msk);
        wr_lane = (old & ~msk) | (nw & msk);
    endfunction

    // resting destination shared by several transitions
    function automatic psc_seq_t rest_dest(input logic lp_state);
        rest_dest = lp_state ? PSC_REST : PSC_IDLE;
    endfunction

    logic       wb_req;
    logic       wb_wr;
    logic [7:0] wd;
    logic       go_cmd;
    logic       halt_cmd;
    logic       tick_sel_zero;
    logic [21:0] tick_len;
    logic [7:0] seq1_w;
    logic [6:0] lvl_need;

    always_comb
    begin
        s_nxt    = s_r;
        wb_req   = WB_CYC_IN && WB_STB_IN && !s_r.wb.ack;
        wb_wr    = wb_req && WB_WE_IN && WB_SEL_IN[0];
        wd       = WB_DAT_IN[7:0];
        go_cmd   = 1'b0;
        halt_cmd = 1'b0;
        seq1_w   = 8'h00;
        s_nxt.wb.ack = wb_req;
        s_nxt.wb.dat = 8'h00;
        if (wb_req)
        begin
            unique case (WB_ADR_IN)
                `PSC_OFF_OPT2:   s_nxt.wb.dat = s_r.regs.opt2;
                `PSC_OFF_LEN_LO: s_nxt.wb.dat = s_r.regs.len_lo;
                `PSC_OFF_OWN:    s_nxt.wb.dat = s_r.regs.own;
                `PSC_OFF_ALL:    s_nxt.wb.dat = s_r.regs.all;
                `PSC_OFF_QSETUP: s_nxt.wb.dat = s_r.regs.qsetup;
                `PSC_OFF_SEQ1:   s_nxt.wb.dat = s_r.regs.seq1;  // R12
                `PSC_OFF_AUX:    s_nxt.wb.dat = s_r.regs.aux;
                `PSC_OFF_STAT:   s_nxt.wb.dat = {1'b0, s_r.chip, s_r.level_irq, 1'b0, s_r.seq};
                default:         s_nxt.wb.dat = 8'h00;  // R22
            endcase
        end
        if (wb_wr)
        begin
            unique case (WB_ADR_IN)
                `PSC_OFF_OPT2:   s_nxt.regs.opt2 = wr_lane(s_r.regs.opt2, wd, `PSC_MASK_OPT2);  // R22
                `PSC_OFF_LEN_LO: s_nxt.regs.len_lo = wd;  // R04
                `PSC_OFF_OWN:    s_nxt.regs.own = wd;  // R06
                `PSC_OFF_ALL:    s_nxt.regs.all = wd;  // R07
                `PSC_OFF_QSETUP: s_nxt.regs.qsetup = wr_lane(s_r.regs.qsetup, wd, `PSC_MASK_QSETUP);
                `PSC_OFF_SEQ1:
                begin
                    seq1_w   = wd;
                    s_nxt.regs.seq1 = wr_lane(s_r.regs.seq1, wd, `PSC_MASK_SEQ1);
                    go_cmd   = wd[7];  // R10
                    halt_cmd = wd[6];  // R12
                end
                `PSC_OFF_AUX:    s_nxt.regs.aux = wr_lane(s_r.regs.aux, wd, `PSC_MASK_AUX);
                default:         s_nxt.regs = s_r.regs;
            endcase
        end

        // timer one tick base; aux[3:2] chooses resolution, aux[1:0] unused here
        tick_sel_zero = (s_r.regs.aux[3:2] == 2'b00);  // R19
        unique case (s_r.regs.aux[3:2])
            2'b01:   tick_len = 22'(TICK1_CYC);
            2'b10:   tick_len = 22'(TICK2_CYC);
            default: tick_len = 22'(TICK3_CYC);
        endcase
        s_nxt.tick       = 1'b0;
        s_nxt.timer1_irq = 1'b0;
        if (tick_sel_zero || s_r.seq != PSC_REST)
        begin
            s_nxt.tick_cnt = 22'h000000;
            s_nxt.coef_cnt = 8'h00;
        end
        else if (s_r.tick_cnt + 22'h000001 >= tick_len)
        begin
            s_nxt.tick_cnt = 22'h000000;
            s_nxt.tick     = 1'b1;  // R19
        end
        else
            s_nxt.tick_cnt = s_r.tick_cnt + 22'h000001;
        if (s_r.tick)
        begin
            // coefficient held in aux[4] scaled: one tick when clear, four when set
            if (s_r.coef_cnt >= {6'h00, s_r.regs.aux[4], s_r.regs.aux[4]})
            begin
                s_nxt.coef_cnt   = 8'h00;
                s_nxt.timer1_irq = 1'b1;
            end
            else
                s_nxt.coef_cnt = s_r.coef_cnt + 8'h01;
        end

        lvl_need = 7'(s_r.regs.qsetup[5:0]) + 7'h01;
        s_nxt.level_irq = 7'(fc_b_r) >= lvl_need;  // R09
        s_nxt.send_go = s_r.regs.qsetup[7] ? (fc_b_r != '0)  // R08
                                            : (7'(fc_b_r) > 7'(s_r.regs.qsetup[5:0]));  // R08

        // address filter modes: own address always, all-stations address only when aux[0] is set
        s_nxt.addr_ok = (ra_b_r == s_r.regs.own)  // R06
                      || (s_r.regs.aux[0] && ra_b_r == s_r.regs.all);  // R07
        s_nxt.len_ok = (BODY_LENGTH_OUT == 11'h000) ? 1'b1
                     : (VARIABLE_LEN_OUT ? (rl_b_r <= BODY_LENGTH_OUT)  // R05
                                         : (rl_b_r == BODY_LENGTH_OUT));  // R05

        unique case (s_r.seq)
            PSC_IDLE:
                if (go_cmd && s_r.chip != PSC_CHIP_ACT)  // R21
                begin
                    unique case (seq1_w[4:3])  // R14
                        2'b00: s_nxt.seq = rest_dest(seq1_w[2]);
                        2'b01: s_nxt.seq = PSC_RECV;
                        2'b10: s_nxt.seq = PSC_SEND;
                        2'b11: s_nxt.seq = PSC_QWAIT;
                    endcase
                end
            PSC_REST:
                if (s_r.timer1_irq)
                    s_nxt.seq = s_r.regs.seq1[1] ? PSC_RECV : PSC_SEND;  // R16
            PSC_SEND:
                if (ev_b_r[1])
                    s_nxt.seq = s_r.regs.seq1[0] ? PSC_RECV : rest_dest(s_r.regs.seq1[2]);  // R17
            PSC_RECV:
                if (ev_b_r[2])
                    s_nxt.seq = rest_dest(s_r.regs.seq1[2]);  // R15
            PSC_QWAIT:
                if (s_r.send_go)
                    s_nxt.seq = PSC_SEND;
            default:
                s_nxt.seq = PSC_IDLE;
        endcase
        if (halt_cmd)
            s_nxt.seq = PSC_IDLE;  // R12

        unique case (s_nxt.seq)
            // new register value, so a write in the same cycle picks the mode at once
            PSC_REST: s_nxt.chip = s_nxt.regs.seq1[5] ? PSC_CHIP_SLEEP : PSC_CHIP_STBY;  // R13
            PSC_IDLE: s_nxt.chip = PSC_CHIP_STBY;
            default:  s_nxt.chip = PSC_CHIP_ACT;
        endcase
    end

    always_ff @(posedge CLK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            s_r <= '0;
            s_r.regs.opt2   <= `PSC_RST_OPT2;  // R01
            s_r.regs.len_lo <= `PSC_RST_LEN_LO;  // R04
            s_r.regs.own    <= `PSC_RST_OWN;
            s_r.regs.all    <= `PSC_RST_ALL;
            s_r.regs.qsetup <= `PSC_RST_QSETUP;
            s_r.regs.seq1   <= `PSC_RST_SEQ1;
            s_r.regs.aux    <= `PSC_RST_AUX;
            s_r.seq         <= PSC_IDLE;  // R21
            s_r.chip        <= PSC_CHIP_STBY;
        end
        else
            s_r <= s_nxt;
    end

    always_ff @(posedge CLK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            WB_DAT_OUT          <= 32'h00000000;
            WB_ACK_OUT          <= 1'b0;
            SEQ_STATE_OUT       <= 3'h0;
            CHIP_MODE_OUT       <= 2'h0;
            QUEUE_LEVEL_IRQ_OUT <= 1'b0;
            SEND_START_OUT      <= 1'b0;
            ADDR_MATCH_OUT      <= 1'b0;
            LEN_OK_OUT          <= 1'b0;
            MARKER_BYTES_OUT    <= 4'h0;
            BODY_LENGTH_OUT     <= 11'h040;
            PACKET_MODE_OUT     <= 1'b1;
            COMPAT_OUT          <= 1'b0;
            BEACON_OUT          <= 1'b0;
            VARIABLE_LEN_OUT    <= 1'b0;
        end
        else
        begin
            WB_DAT_OUT          <= {24'h000000, s_nxt.wb.dat};
            WB_ACK_OUT          <= s_nxt.wb.ack;
            SEQ_STATE_OUT       <= s_nxt.seq;
            CHIP_MODE_OUT       <= s_nxt.chip;
            QUEUE_LEVEL_IRQ_OUT <= s_nxt.level_irq;  // R09
            SEND_START_OUT      <= s_nxt.send_go && s_nxt.seq == PSC_SEND;  // R08
            ADDR_MATCH_OUT      <= s_nxt.addr_ok;
            LEN_OK_OUT          <= s_nxt.len_ok;
            // marker size field kept in aux[7:5] would exceed mask; use compat rule on field 3
            MARKER_BYTES_OUT    <= s_nxt.regs.opt2[5] ? 4'h3 : 4'h4;  // R20
            BODY_LENGTH_OUT     <= {s_nxt.regs.opt2[2:0], s_nxt.regs.len_lo};  // R04
            PACKET_MODE_OUT     <= s_nxt.regs.opt2[6];  // R01
            COMPAT_OUT          <= s_nxt.regs.opt2[5];  // R02
            BEACON_OUT          <= s_nxt.regs.opt2[3] && !s_nxt.regs.aux[1];  // R03
            VARIABLE_LEN_OUT    <= s_nxt.regs.aux[1];  // R18
        end
    end

    chk_halt_idle: assert property (@(posedge CLK_IN) disable iff (RESET_IN)  // R12
        (WB_ACK_OUT && $past(WB_WE_IN) && $past(WB_ADR_IN) == `PSC_OFF_SEQ1 && $past(WB_DAT_IN[6])) |->
        SEQ_STATE_OUT == 3'h0) else $error("halt did not force idle");
    chk_go_send: assert property (@(posedge CLK_IN) disable iff (RESET_IN)  // R14
        ($past(s_r.seq) == PSC_IDLE && $past(go_cmd) && !$past(halt_cmd) && $past(seq1_w[4:3]) == 2'b10
         && $past(s_r.chip) != PSC_CHIP_ACT) |-> s_r.seq == PSC_SEND) else $error("start to send missed");
    chk_rest_chip: assert property (@(posedge CLK_IN) disable iff (RESET_IN)  // R13
        SEQ_STATE_OUT == 3'h1 |-> CHIP_MODE_OUT == {1'b0, s_r.regs.seq1[5]}) else $error("rest chip mode wrong");
    chk_level_irq: assert property (@(posedge CLK_IN) disable iff (RESET_IN)  // R09
        QUEUE_LEVEL_IRQ_OUT == ($past(fc_b_r) > $past(s_r.regs.qsetup[5:0])))
        else $error("level irq wrong");
    chk_halt_read: assert property (@(posedge CLK_IN) disable iff (RESET_IN)  // R12
        s_r.regs.seq1[7:6] == 2'b00) else $error("command bits stored");
    chk_len_join: assert property (@(posedge CLK_IN) disable iff (RESET_IN)  // R04
        BODY_LENGTH_OUT == {s_r.regs.opt2[2:0], s_r.regs.len_lo}) else $error("length join");
    chk_timer_rest: assert property (@(posedge CLK_IN) disable iff (RESET_IN)  // R16
        (s_r.seq == PSC_REST && s_r.timer1_irq && !halt_cmd) |=> s_r.seq == ($past(s_r.regs.seq1[1]) ? PSC_RECV : PSC_SEND))
        else $error("timer transition wrong");
    chk_frame_done: assert property (@(posedge CLK_IN) disable iff (RESET_IN)  // R17
        (s_r.seq == PSC_SEND && ev_b_r[1] && !halt_cmd && s_r.regs.seq1[0]) |=> s_r.seq == PSC_RECV)
        else $error("send to receive missed");
    cov_start: cover property (@(posedge CLK_IN) disable iff (RESET_IN) s_r.seq == PSC_IDLE ##1 s_r.seq == PSC_SEND);
    cov_rest: cover property (@(posedge CLK_IN) disable iff (RESET_IN) s_r.seq == PSC_REST ##1 s_r.seq == PSC_RECV);
    cov_qwait: cover property (@(posedge CLK_IN) disable iff (RESET_IN) s_r.seq == PSC_QWAIT ##1 s_r.seq == PSC_SEND);
endmodule : psc_top
`default_nettype wire

// ---- bench/psc_host_model.sv ----
// wishbone host model issuing classic register cycles
`timescale 1ns/1ps
`default_nettype none
module psc_host_model (
    input  wire logic        clk_in,
    output var  logic        cyc_out,
    output var  logic        stb_out,
    output var  logic        we_out,
    output var  logic [7:0]  adr_out,
    output var  logic [3:0]  sel_out,
    output var  logic [31:0] dat_out,
    input  wire logic [31:0] dat_in,
    input  wire logic        ack_in
);
    initial
    begin
        cyc_out = 1'b0;
        stb_out = 1'b0;
        we_out  = 1'b0;
        adr_out = 8'h00;
        sel_out = 4'h0;
        dat_out = 32'h0;
    end

    // gap lets the host be slow between cycles; ok low means no ack came
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd, input int gap,
                        output logic [7:0] rd, output logic ok);
        int n;
        ok = 1'b0;
        rd = 8'h00;
        @(posedge clk_in);
        cyc_out <= 1'b1;
        stb_out <= 1'b1;
        we_out  <= we;
        adr_out <= adr;
        sel_out <= 4'h1;
        dat_out <= {24'h0, wd};
        for (n = 0; n < 50 && !ok; n++)
        begin
            @(posedge clk_in);
            if (ack_in === 1'b1)
            begin
                ok = 1'b1;
                rd = dat_in[7:0];
            end
        end
        cyc_out <= 1'b0;
        stb_out <= 1'b0;
        we_out  <= 1'b0;
        repeat (gap) @(posedge clk_in);
    endtask
endmodule // psc_host_model
`default_nettype wire

// ---- bench/psc_top_test.sv ----
// self-checking bench for the packet sequencer block
`timescale 1ns/1ps
`default_nettype none
module psc_top_test;
    import psc_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst;
    logic        cyc, stb, we, ack;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [6:0]  fifo_cnt;
    logic        frame_done, rx_done;
    logic [7:0]  rx_addr;
    logic [10:0] rx_len, body_len;
    logic [2:0]  seq_st;
    logic [1:0]  chip;
    logic        lvl_irq, send_go, addr_ok, len_ok, pkt, compat, beacon, varlen;
    logic [3:0]  marker;
    logic [7:0]  rst_tab [6] = '{8'h40, 8'h40, 8'h00, 8'h00, 8'h0f, 8'h00};
    int          errors = 0;
    int          n_checks = 0;

    always #50 clk_in = ~clk_in;

    psc_host_model psc_host_model_i (.clk_in(clk_in), .cyc_out(cyc), .stb_out(stb), .we_out(we),
        .adr_out(adr), .sel_out(sel), .dat_out(wdat), .dat_in(rdat), .ack_in(ack));

    psc_top #(.TICK1_CYC(4), .TICK2_CYC(8), .TICK3_CYC(16), .FIFO_W(7)) psc_top_i (
        .CLK_IN(clk_in), .RESET_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
        .FIFO_COUNT_IN(fifo_cnt), .FRAME_DONE_IN(frame_done), .RX_DONE_IN(rx_done),
        .RX_ADDR_IN(rx_addr), .RX_LEN_IN(rx_len), .SEQ_STATE_OUT(seq_st), .CHIP_MODE_OUT(chip),
        .QUEUE_LEVEL_IRQ_OUT(lvl_irq), .SEND_START_OUT(send_go), .ADDR_MATCH_OUT(addr_ok),
        .LEN_OK_OUT(len_ok), .MARKER_BYTES_OUT(marker), .BODY_LENGTH_OUT(body_len),
        .PACKET_MODE_OUT(pkt), .COMPAT_OUT(compat), .BEACON_OUT(beacon), .VARIABLE_LEN_OUT(varlen));

    task automatic tally_and_finish;
        if (errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       ok;
        psc_host_model_i.xfer(1'b1, a, d, 0, r, ok);
        if (!ok)
        begin
            errors++;
            $display("ERROR %0t no ack on write", $time);
            tally_and_finish();
        end
    endtask

    // random gap exercises a slow host between reads
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        logic       ok;
        psc_host_model_i.xfer(1'b0, a, 8'h00, $urandom_range(0, 2), r, ok);
        if (!ok)
        begin
            errors++;
            $display("ERROR %0t no ack on read", $time);
            tally_and_finish();
        end
        check(r, e, "reg read");
    endtask

    task automatic wait_st(input logic [2:0] e);
        int n;
        for (n = 0; n < 400 && seq_st !== e; n++)
            @(posedge clk_in);
        check(seq_st, e, "seq state");
        if (seq_st !== e)
            tally_and_finish();
    endtask

    function automatic logic [2:0] go_dest(input logic [1:0] nx, input logic rest);
        case (nx)
            2'b00: return rest ? 3'd1 : 3'd0;
            2'b01: return 3'd2;
            2'b10: return 3'd3;
            default: return 3'd4;
        endcase
    endfunction

    initial
    begin
        logic [7:0]  o, l, a, ow, al, q, s, rxa;
        logic [6:0]  cnt;
        logic [10:0] bl;
        logic [2:0]  d;
        void'($urandom(32'h152a379e));
        rst = 1'b1;
        fifo_cnt = 7'h00;
        frame_done = 1'b0;
        rx_done = 1'b0;
        rx_addr = 8'h00;
        rx_len = 11'h000;
        repeat (8) @(posedge clk_in);
        rst <= 1'b0;
        @(posedge clk_in);
        check(body_len, 11'h040, "len reset");
        check(pkt, 1'b1, "mode reset");
        check(seq_st, 3'd0, "seq reset");
        for (int i = 0; i < 6; i++)
            rd_chk(8'h31 + 8'(i), rst_tab[i]);
        wr(8'h30, 8'hff);
        rd_chk(8'h30, 8'h00);
        rd_chk(8'h37, 8'h00);
        rd_chk(8'h3a, 8'h0b);
        for (int it = 0; it < 40; it++)
        begin
            o = 8'($urandom);
            l = 8'($urandom);
            a = 8'($urandom);
            ow = 8'($urandom);
            al = 8'($urandom);
            q = 8'($urandom);
            bl = {o[2:0], l};
            case ($urandom_range(0, 2))
                0: rxa = ow;
                1: rxa = al;
                default: rxa = 8'($urandom);
            endcase
            wr(8'h31, o);
            wr(8'h32, l);
            wr(8'h3a, a);
            wr(8'h33, ow);
            wr(8'h34, al);
            wr(8'h35, q);
            cnt = (it % 3 == 0) ? 7'(q[5:0]) : (it % 3 == 1) ? 7'(q[5:0]) + 7'd1 : 7'($urandom);
            fifo_cnt <= cnt;
            rx_addr <= rxa;
            case (it % 4)
                0: rx_len <= bl;
                1: rx_len <= bl + 11'd1;
                2: rx_len <= bl - 11'd1;
                default: rx_len <= 11'($urandom);
            endcase
            repeat (6) @(posedge clk_in);
            check(body_len, bl, "body length");
            check(pkt, o[6], "data path");
            check(compat, o[5], "compat");
            check(beacon, o[3] & ~a[1], "beacon");
            check(varlen, a[1], "format");
            check(marker, o[5] ? 4'd3 : 4'd4, "marker");
            check(addr_ok, rxa == ow || (a[0] && rxa == al), "address");
            check(len_ok, bl == 0 || (a[1] ? rx_len <= bl : rx_len == bl), "length");
            check(lvl_irq, cnt >= 7'(q[5:0]) + 7'd1, "level irq");
            rd_chk(8'h31, o & 8'h7f);
            rd_chk(8'h35, q & 8'hbf);
            rd_chk(8'h3a, a & 8'h1f);
            rd_chk(8'h3b, {3'b000, cnt >= 7'(q[5:0]) + 7'd1, 4'h0});
        end
        fifo_cnt <= 7'h00;
        wr(8'h3a, 8'h04);
        for (int k = 0; k < 16; k++)
        begin
            s = {2'b00, 1'($urandom), 2'(k), k[2], k[3], 1'($urandom)};
            wr(8'h36, s | 8'h40);
            repeat (2) @(posedge clk_in);
            check(seq_st, 3'd0, "halt");
            wr(8'h36, s | 8'h80);
            repeat (2) @(posedge clk_in);
            d = go_dest(s[4:3], s[2]);
            check(seq_st, d, "start");
            if (d == 3'd1)
                check(chip, {1'b0, s[5]}, "rest chip");
            rd_chk(8'h36, s);
            if (d == 3'd1)
                wait_st(s[1] ? 3'd2 : 3'd3);
            if (seq_st === 3'd2)
            begin
                wr(8'h36, s | 8'h80);
                repeat (2) @(posedge clk_in);
                check(seq_st, 3'd2, "start ignored");
                rx_done <= 1'b1;
                repeat (3) @(posedge clk_in);
                rx_done <= 1'b0;
                wait_st(s[2] ? 3'd1 : 3'd0);
            end
            if (seq_st === 3'd4)
            begin
                fifo_cnt <= 7'h7f;
                wait_st(3'd3);
                fifo_cnt <= 7'h00;
            end
            if (seq_st === 3'd3)
            begin
                q = {1'($urandom), 1'b0, 6'($urandom)};
                cnt = k[0] ? 7'(q[5:0]) : 7'(q[5:0]) + 7'd1;
                if (q[7])
                    cnt = 7'(k[0]);
                wr(8'h35, q);
                fifo_cnt <= cnt;
                repeat (6) @(posedge clk_in);
                check(send_go, q[7] ? cnt != 0 : cnt > 7'(q[5:0]), "send trigger");
                frame_done <= 1'b1;
                repeat (3) @(posedge clk_in);
                frame_done <= 1'b0;
                wait_st(s[0] ? 3'd2 : (s[2] ? 3'd1 : 3'd0));
                fifo_cnt <= 7'h00;
            end
        end
        tally_and_finish();
    end
endmodule // psc_top_test
`default_nettype wire
